// [include/flash_seq_pkg.sv]
package flash_seq_pkg;
  // ==========================================================
  // Control register layout
  localparam int KEY_MSB = 7;
  localparam int KEY_LSB = 4;
  localparam int MAP_BIT = 3;
  localparam int SPACE_MSB = 2;
  localparam int SPACE_LSB = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [3:0] KEY_ARM = 4'h5;
  localparam logic [3:0] KEY_FIRE = 4'ha;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ==========================================================
  // Register indexes on the plain port
  localparam logic [1:0] ADDR_FLASH_CTRL = 2'h0;
  localparam logic [1:0] ADDR_AUX1 = 2'h1;
  localparam logic [1:0] ADDR_AUX = 2'h2;
  localparam logic [1:0] ADDR_LOCK = 2'h3;
  localparam int BOOT_MAP_BIT = 0;
  localparam int EXT_RAM_BIT = 1;
  // ==========================================================
  // Address map
  localparam logic [15:0] USER_TOP = 16'h7fff;
  localparam logic [15:0] EXTRA_ROW_BASE = 16'hff80;
  localparam logic [15:0] BOOT_BASE = 16'hf800;
  localparam logic [15:0] SEC_ADDR = 16'h0000;
  localparam int OFS_MSB = 6;
  localparam int PAGE_MSB = 14;
  localparam int PAGE_LSB = 7;
  localparam int PAGE_BYTES = 128;
  localparam logic [2:0] LOCK_RESET = 3'h4;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int ERASE_US = 10;
  localparam int PROG_US = 10;
  localparam int ERASE_CYC = ERASE_US * (CLK_HZ / 1_000_000);
  localparam int PROG_CYC = PROG_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    SP_USER = 2'b00,
    SP_EXTRA_ROW = 2'b01,
    SP_SEC = 2'b10,
    SP_RSVD = 2'b11
  } space_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG = 2'b10
  } phase_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic xwr;
    logic xrd;
    logic crd;
    logic from_boot;
    logic from_ext;
  } cpu_req_t;

  typedef struct packed {
    logic latch_wr;
    logic xram_wr;
    logic xram_rd;
    logic user_rd;
    logic extra_row_rd;
    logic sec_rd;
    logic boot_rd;
    logic ext_rd;
    logic barred;
    logic [15:0] addr;
  } route_t;
endpackage

// [verilog/user_flash_program_sequencer.sv]
// What this block does
// - Latch-map set: data writes 0000h-7FFFh go to the column latches
// - Address bits 6:0 pick latch byte, bits 14:7 pick the page
// - Latch-map select wins over the external RAM select
// - After reset the user array is read-only through code reads
// - Space select maps code reads: user, extra row, security byte, reserved
// - Launch only after key 5 then key A in control bits 7:4
// - Key A acts per space select; reserved space and key 5 do nothing
// - One instruction between the two key writes is allowed; a second one aborts the launch
// - Busy flag high during erase and program, cleared at completion
// - Boot-map enable maps boot flash at F800h-FFFFh in code space
// - One to 128 latch loads accepted, loaded bytes tracked
// - Launch erases then programs only loaded bytes of the page
// - Page of the latest latch load is the target page
// - Launch honoured only when the key A write runs from boot flash
// - Three lock bits give levels 1-4, default level 4
// - Levels 2-4 bar external reads; level 4 blocks roll-over execution
// - Control: key 7:4, latch map 3, space 2:1, busy 0
// - Busy bit is hardware only; software writes ignored
module user_flash_program_sequencer #(
  parameter int ERASE_CYCLES = flash_seq_pkg::ERASE_CYC,
  parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire flash_seq_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire flash_seq_pkg::cpu_req_t cpu_req,
  input wire logic instr_done,
  output flash_seq_pkg::route_t route,
  output logic [7:0] latch_rdata,
  output logic prog_start,
  output logic prog_busy_flag,
  output logic [1:0] prog_space,
  output logic [7:0] prog_page,
  output logic [flash_seq_pkg::PAGE_BYTES-1:0] prog_mask,
  output logic erase_phase,
  output logic ext_access_latched
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [3:0] launch_key;
    logic latch_map_select;
    logic [1:0] space_select;
    logic boot_map_enable;
    logic ext_ram_select;
    logic [2:0] lock_bits;
    logic armed;
    logic arm_gap;
    flash_seq_pkg::phase_t phase;
    logic [15:0] count;
    logic [1:0] op_space;
    logic [7:0] page;
    logic [flash_seq_pkg::PAGE_BYTES-1:0] loaded;
    logic start;
    logic ea_latched;
    logic ea_caught;
    logic [7:0] rdata;
    logic [7:0] ldata;
    flash_seq_pkg::route_t route;
    logic busy;
    logic erasing;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [7:0] latch_mem [flash_seq_pkg::PAGE_BYTES];
  logic [6:0] ofs;

  // Level from lock bits: 1 none, 2..4 one programmed bit each
  function automatic logic [2:0] lock_level(input logic [2:0] lb);
    logic [2:0] lvl;
    lvl = 3'h1;
    if (lb[2]) begin
      lvl = 3'h4;
    end else if (lb[1]) begin
      lvl = 3'h3;
    end else if (lb[0]) begin
      lvl = 3'h2;
    end
    return lvl;
  endfunction

  assign ofs = cpu_req.addr[flash_seq_pkg::OFS_MSB:0];

  // ==========================================================
  // Next state
  always_comb begin
    logic busy;
    logic [3:0] key;
    logic is_key_wr;
    logic [2:0] lvl;
    logic in_user;
    busy = 1'b0;
    key = reg_req.wdata[flash_seq_pkg::KEY_MSB:flash_seq_pkg::KEY_LSB];
    is_key_wr = 1'b0;
    lvl = lock_level(state_reg.lock_bits);
    in_user = cpu_req.addr <= flash_seq_pkg::USER_TOP;
    state_next = state_reg;
    state_next.start = 1'b0;
    busy = state_reg.phase != flash_seq_pkg::ST_IDLE;

    if (!state_reg.ea_caught) begin
      state_next.ea_caught = 1'b1;
      state_next.ea_latched = cpu_req.from_ext && (lvl >= 3'h2);
    end

    // The second completed instruction after arming closes the pair; the first only marks the gap
    if (instr_done && state_reg.armed && !state_reg.arm_gap) begin
      state_next.arm_gap = 1'b1;
    end else if (instr_done && state_reg.arm_gap) begin
      state_next.armed = 1'b0;
      state_next.arm_gap = 1'b0;
    end

    // Register writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        flash_seq_pkg::ADDR_FLASH_CTRL: begin
          state_next.latch_map_select = reg_req.wdata[flash_seq_pkg::MAP_BIT];
          state_next.space_select =
            reg_req.wdata[flash_seq_pkg::SPACE_MSB:flash_seq_pkg::SPACE_LSB];
          state_next.launch_key = key;
          is_key_wr = !busy;
        end
        flash_seq_pkg::ADDR_AUX1: begin
          state_next.boot_map_enable = reg_req.wdata[flash_seq_pkg::BOOT_MAP_BIT];
        end
        flash_seq_pkg::ADDR_AUX: begin
          state_next.ext_ram_select = reg_req.wdata[flash_seq_pkg::EXT_RAM_BIT];
        end
        flash_seq_pkg::ADDR_LOCK: begin
          // Lock bits change only through parallel mode, never here
        end
      endcase
    end

    if (is_key_wr) begin
      state_next.arm_gap = 1'b0;
      if (key == flash_seq_pkg::KEY_ARM) begin
        state_next.armed = 1'b1;
      end else begin
        state_next.armed = 1'b0;
        if (key == flash_seq_pkg::KEY_FIRE && state_reg.armed &&
            cpu_req.from_boot &&
            state_next.space_select != flash_seq_pkg::SP_RSVD) begin
          state_next.phase = flash_seq_pkg::ST_ERASE;
          state_next.op_space = state_next.space_select;
          state_next.count = 16'h0000;
          state_next.start = 1'b1;
        end
      end
    end

    // Erase of loaded bytes, then program, then release the latches
    unique case (state_reg.phase)
      flash_seq_pkg::ST_IDLE: begin
      end
      flash_seq_pkg::ST_ERASE: begin
        state_next.count = state_reg.count + 16'h0001;
        if (state_reg.count == 16'(ERASE_CYCLES - 1)) begin
          state_next.phase = flash_seq_pkg::ST_PROG;
          state_next.count = 16'h0000;
        end
      end
      flash_seq_pkg::ST_PROG: begin
        state_next.count = state_reg.count + 16'h0001;
        if (state_reg.count == 16'(PROG_CYCLES - 1)) begin
          state_next.phase = flash_seq_pkg::ST_IDLE;
          state_next.loaded = '0;
        end
      end
      default: begin
        state_next.phase = flash_seq_pkg::ST_IDLE;
      end
    endcase

    // Routing of the current CPU access
    state_next.route = '0;
    state_next.route.addr = cpu_req.addr;
    if (cpu_req.xwr) begin
      if (state_reg.latch_map_select && in_user && !busy) begin
        state_next.route.latch_wr = 1'b1;
        state_next.loaded[ofs] = 1'b1;
        state_next.page = cpu_req.addr[flash_seq_pkg::PAGE_MSB:flash_seq_pkg::PAGE_LSB];
      end else begin
        state_next.route.xram_wr = 1'b1;
      end
    end
    if (cpu_req.xrd) begin
      state_next.route.xram_rd = 1'b1;
    end
    if (cpu_req.crd) begin
      if (cpu_req.from_ext && lvl >= 3'h2) begin
        state_next.route.barred = 1'b1;
      end else if (cpu_req.from_ext && lvl == 3'h4 && !in_user) begin
        state_next.route.barred = 1'b1;
      end else if (state_reg.boot_map_enable &&
                   cpu_req.addr >= flash_seq_pkg::BOOT_BASE) begin
        state_next.route.boot_rd = 1'b1;
      end else begin
        unique case (flash_seq_pkg::space_t'(state_reg.space_select))
          flash_seq_pkg::SP_USER: begin
            state_next.route.user_rd = in_user;
            state_next.route.ext_rd = !in_user;
          end
          flash_seq_pkg::SP_EXTRA_ROW: begin
            state_next.route.extra_row_rd = cpu_req.addr >= flash_seq_pkg::EXTRA_ROW_BASE;
            state_next.route.user_rd = in_user;
          end
          flash_seq_pkg::SP_SEC: begin
            state_next.route.sec_rd = cpu_req.addr == flash_seq_pkg::SEC_ADDR;
          end
          flash_seq_pkg::SP_RSVD: begin
          end
        endcase
      end
    end

    // Register read data, one cycle later
    state_next.rdata = 8'h00;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        flash_seq_pkg::ADDR_FLASH_CTRL: begin
          state_next.rdata = {state_reg.launch_key, state_reg.latch_map_select,
                              state_reg.space_select, busy};
        end
        flash_seq_pkg::ADDR_AUX1: begin
          state_next.rdata[flash_seq_pkg::BOOT_MAP_BIT] = state_reg.boot_map_enable;
        end
        flash_seq_pkg::ADDR_AUX: begin
          state_next.rdata[flash_seq_pkg::EXT_RAM_BIT] = state_reg.ext_ram_select;
        end
        flash_seq_pkg::ADDR_LOCK: begin
          state_next.rdata = {5'h00, state_reg.lock_bits};
        end
      endcase
    end
    state_next.ldata = latch_mem[ofs];
    // Status outputs registered so they leave straight from flops
    state_next.busy = state_next.phase != flash_seq_pkg::ST_IDLE;
    state_next.erasing = state_next.phase == flash_seq_pkg::ST_ERASE;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.lock_bits <= flash_seq_pkg::LOCK_RESET;
      state_reg.phase <= flash_seq_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Latch array has no reset; only loaded bytes are ever used
  always_ff @(posedge sys_clk) begin
    if (state_next.route.latch_wr) begin
      latch_mem[ofs] <= cpu_req.wdata;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign route = state_reg.route;
  assign latch_rdata = state_reg.ldata;
  assign prog_start = state_reg.start;
  assign prog_busy_flag = state_reg.busy;
  assign prog_space = state_reg.op_space;
  assign prog_page = state_reg.page;
  assign prog_mask = state_reg.loaded;
  assign erase_phase = state_reg.erasing;
  assign ext_access_latched = state_reg.ea_latched;
endmodule

// [bench/flash_seq_sva.sv]
module flash_seq_sva #(
  parameter int ERASE_CYCLES = 4,
  parameter int PROG_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire flash_seq_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire flash_seq_pkg::cpu_req_t cpu_req,
  input wire flash_seq_pkg::route_t route,
  input wire logic prog_start,
  input wire logic prog_busy_flag,
  input wire logic [1:0] prog_space,
  input wire logic [flash_seq_pkg::PAGE_BYTES-1:0] prog_mask
);
  // ====
  // Mirror of map and space bits, busy span counter
  logic [3:1] mode_reg;
  logic [15:0] cnt_reg;
  logic boot_reg;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mode_reg <= '0;
      cnt_reg <= '0;
      boot_reg <= 1'b0;
    end else begin
      if (reg_req.wr && reg_req.addr == flash_seq_pkg::ADDR_FLASH_CTRL) begin
        mode_reg <= reg_req.wdata[3:1];
      end
      // Boot map overlaps the extra row window, so track it too
      if (reg_req.wr && reg_req.addr == flash_seq_pkg::ADDR_AUX1) begin
        boot_reg <= reg_req.wdata[flash_seq_pkg::BOOT_MAP_BIT];
      end
      cnt_reg <= prog_busy_flag ? cnt_reg + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_latch_route:
    assert property (cpu_req.xwr && !cpu_req.addr[15] && mode_reg[3] && !prog_busy_flag
      && !cpu_req.from_ext |=> route.latch_wr && !route.xram_wr) else $error("latch route");
  a_no_latch_hi:
    assert property (cpu_req.xwr && cpu_req.addr[15] |=> !route.latch_wr) else $error("hi latch");
  a_extra_row_route:
    assert property (cpu_req.crd && mode_reg[2:1] == 2'b01 && !cpu_req.from_ext && !boot_reg
      && cpu_req.addr >= flash_seq_pkg::EXTRA_ROW_BASE |=> route.extra_row_rd) else $error("extra_row map");
  a_rdata_idle:
    assert property (!reg_req.rd |=> reg_rdata == 8'h00) else $error("stray read data");
  a_start_cause:
    assert property (prog_start |-> $past(reg_req.wr) && $past(cpu_req.from_boot)
      && $past(reg_req.wdata[7:4]) == flash_seq_pkg::KEY_FIRE) else $error("bad launch");
  a_rsvd_space:
    assert property (prog_start |-> prog_busy_flag && prog_space != flash_seq_pkg::SP_RSVD)
      else $error("launch state");
  a_no_restart:
    assert property ($past(prog_busy_flag) |-> !prog_start) else $error("restart while busy");
  a_busy_span:
    assert property ($fell(prog_busy_flag) |-> cnt_reg == ERASE_CYCLES + PROG_CYCLES)
      else $error("busy length");
  a_mask_clear:
    assert property ($fell(prog_busy_flag) |-> prog_mask == '0) else $error("mask kept");
  c_launch: cover property (prog_start);
  c_latch: cover property (route.latch_wr);
  c_done: cover property ($fell(prog_busy_flag));
endmodule
bind user_flash_program_sequencer flash_seq_sva #(.ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)) u_sva (.sys_clk, .nrst, .reg_req, .reg_rdata, .cpu_req,
  .route, .prog_start, .prog_busy_flag, .prog_space, .prog_mask);

// [bench/cpu_core_model.sv]
module cpu_core_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  input wire flash_seq_pkg::route_t route,
  output flash_seq_pkg::reg_req_t reg_req,
  output flash_seq_pkg::cpu_req_t cpu_req,
  output logic instr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // Core side; never takes an interrupt, so no spurious exit
  initial begin
    reg_req = '0;
    cpu_req = '0;
    cpu_req.from_ext = 1'b1;
    instr_done = 1'b0;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
    reg_req.wdata <= ~d;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    // Mid-cycle, where the read data stand, clear of the edge race
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  // Kind 0 data write, 1 data read, 2 code read; released address is inverted
  task automatic acc(input logic [15:0] a, input int k, output flash_seq_pkg::route_t r);
    @(posedge sys_clk);
    cpu_req.addr <= a;
    cpu_req.wdata <= a[7:0];
    {cpu_req.xwr, cpu_req.xrd, cpu_req.crd} <= 3'b100 >> k;
    @(posedge sys_clk);
    {cpu_req.xwr, cpu_req.xrd, cpu_req.crd} <= 3'b000;
    cpu_req.addr <= ~a;
    @(negedge sys_clk);
    r = route;
  endtask
  task automatic pulse();
    @(posedge sys_clk);
    instr_done <= 1'b1;
    @(posedge sys_clk);
    instr_done <= 1'b0;
  endtask
  task automatic loc(input logic b, input logic e);
    @(posedge sys_clk);
    cpu_req.from_boot <= b;
    cpu_req.from_ext <= e;
  endtask
  task automatic key_pair(input logic [3:0] lo, input int gaps);
    wr(2'h0, {4'h5, lo});
    repeat (gaps) pulse();
    wr(2'h0, {4'ha, lo});
  endtask
endmodule

// [bench/user_flash_program_sequencer_tb.sv]
module user_flash_program_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int E = 4;
  localparam int P = 4;
  localparam logic [1:0] CTRL = flash_seq_pkg::ADDR_FLASH_CTRL;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  flash_seq_pkg::reg_req_t reg_req;
  flash_seq_pkg::cpu_req_t cpu_req;
  flash_seq_pkg::route_t route, r;
  logic instr_done, prog_start, prog_busy_flag, erase_phase, ext_access_latched;
  logic [7:0] reg_rdata, latch_rdata, prog_page, d;
  logic [1:0] prog_space;
  logic [127:0] prog_mask;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #25 sys_clk = ~sys_clk;
  user_flash_program_sequencer #(.ERASE_CYCLES(E), .PROG_CYCLES(P)) u_dut (.sys_clk, .nrst,
    .reg_req, .reg_rdata, .cpu_req, .instr_done, .route, .latch_rdata, .prog_start,
    .prog_busy_flag, .prog_space, .prog_page, .prog_mask, .erase_phase, .ext_access_latched);
  cpu_core_model u_cpu (.sys_clk, .reg_rdata, .route, .reg_req, .cpu_req, .instr_done);
  // ====
  // Helpers
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (!ok) begin
      err_count++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic no_start(input string m);
    @(negedge sys_clk);
    chk(prog_start === 1'b0 && prog_busy_flag === 1'b0, m);
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    while (prog_busy_flag === 1'b1 && n < 50) begin
      n++;
      @(negedge sys_clk);
    end
  endtask
  // ====
  // Scenarios
  task automatic t_reset();
    chk(ext_access_latched === 1'b1, "ext access pin");
    u_cpu.acc(16'h0010, 0, r);
    chk(r.latch_wr === 1'b0, "write path open");
    u_cpu.rd(CTRL, d);
    chk(d === flash_seq_pkg::CTRL_RESET, "ctrl reset");
    u_cpu.wr(flash_seq_pkg::ADDR_LOCK, 8'h00);
    u_cpu.rd(flash_seq_pkg::ADDR_LOCK, d);
    chk(d[2:0] === flash_seq_pkg::LOCK_RESET, "lock bits");
    u_cpu.acc(16'h0010, 2, r);
    chk(r.barred === 1'b1, "external read");
    u_cpu.wr(CTRL, 8'h0d);
    u_cpu.rd(CTRL, d);
    chk(d === 8'h0c, "busy writable");
    u_cpu.loc(1'b0, 1'b0);
    $display("t_reset done");
  endtask
  task automatic t_map();
    logic [15:0] a [3] = '{16'h0010, 16'hff80, 16'h0000};
    for (int s = 0; s < 3; s++) begin
      u_cpu.wr(CTRL, {5'h00, s[1:0], 1'b0});
      u_cpu.acc(a[s], 2, r);
      chk({r.user_rd, r.extra_row_rd, r.sec_rd} === 3'b100 >> s, "space map");
    end
    u_cpu.wr(flash_seq_pkg::ADDR_AUX1, 8'h01);
    u_cpu.wr(CTRL, 8'h00);
    u_cpu.acc(16'hf800, 2, r);
    chk(r.boot_rd === 1'b1, "boot map");
    u_cpu.wr(flash_seq_pkg::ADDR_AUX1, 8'h00);
    $display("t_map done");
  endtask
  task automatic t_load();
    u_cpu.wr(flash_seq_pkg::ADDR_AUX, 8'h02);
    u_cpu.wr(CTRL, 8'h08);
    u_cpu.acc(16'h1283, 0, r);
    chk(r.latch_wr === 1'b1 && r.xram_wr === 1'b0, "latch route");
    u_cpu.acc(16'h8000, 0, r);
    chk(r.latch_wr === 1'b0, "above 7fff");
    u_cpu.acc(16'h7fff, 0, r);
    u_cpu.acc(16'h0105, 0, r);
    chk(prog_mask === (128'h1 << 3 | 128'h1 << 5 | 128'h1 << 127), "mask");
    u_cpu.acc(16'h0003, 1, r);
    chk(latch_rdata === 8'h83 && r.xram_rd === 1'b1, "latch byte");
    u_cpu.wr(CTRL, 8'h00);
    $display("t_load done");
  endtask
  task automatic t_launch();
    int n;
    u_cpu.loc(1'b1, 1'b0);
    for (int s = 0; s < 4; s++) begin
      u_cpu.key_pair({1'b0, s[1:0], 1'b0}, 1);
      @(negedge sys_clk);
      chk(prog_start === (s != 3), "launch");
      if (s == 0) chk(prog_page === 8'h02, "page");
      if (s != 3) begin
        chk(erase_phase === 1'b1 && prog_space === s[1:0], "space");
        wait_idle(n);
        chk(n == E + P && prog_mask === '0, "busy span");
      end
    end
    u_cpu.key_pair(4'h0, 1);
    u_cpu.wr(CTRL, 8'h50);
    u_cpu.rd(CTRL, d);
    chk(d[0] === 1'b1, "busy bit");
    wait_idle(n);
    u_cpu.wr(CTRL, 8'ha0);
    no_start("key while busy");
    $display("t_launch done");
  endtask
  task automatic t_refuse();
    u_cpu.loc(1'b0, 1'b0);
    u_cpu.key_pair(4'h0, 1);
    no_start("not from boot");
    u_cpu.loc(1'b1, 1'b0);
    u_cpu.key_pair(4'h0, 2);
    no_start("gap");
    u_cpu.wr(CTRL, 8'h50);
    no_start("arm only");
    u_cpu.wr(CTRL, 8'h30);
    u_cpu.wr(CTRL, 8'ha0);
    no_start("disarm");
    $display("t_refuse done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Whole run is well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_map();
    t_load();
    t_launch();
    t_refuse();
    end_of_test();
  end
endmodule
